// >>> esmc_pkg.sv
// Constants and carrier types for the extended system-management memory control block
package esmc_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_OFFSET     = 8'h71;
  localparam logic [7:0] CTRL_RESET      = 8'h00;
  localparam int         BIT_HIGH_EN     = 7;
  localparam int         BIT_ERROR       = 6;
  localparam int         BIT_CACHE_POL   = 5;
  localparam int         BIT_L1_ALLOW    = 4;
  localparam int         BIT_L2_ALLOW    = 3;
  localparam int         BIT_SIZE_HI     = 2;
  localparam int         BIT_SIZE_LO     = 1;
  localparam int         BIT_TOP_OF_MEMORY_SEGMENT_ON     = 0;
  localparam logic       CACHE_POL_WB    = 1'b0;

  // ----------------------------------------------------------------
  // Address map
  // ----------------------------------------------------------------
  localparam logic [31:0] HIGH_BASE      = 32'h100a_0000;
  localparam logic [31:0] HIGH_SIZE      = 32'h0002_0000;
  localparam logic [31:0] COMPAT_BASE    = 32'h000a_0000;
  localparam logic [31:0] COMPAT_SIZE    = 32'h0002_0000;
  localparam logic [31:0] TOP_OF_MEMORY_SEGMENT_PHYS_OFS  = 32'h1000_0000;
  localparam logic [31:0] TOP_OF_MEMORY_SEGMENT_SZ_128K   = 32'h0002_0000;
  localparam logic [31:0] TOP_OF_MEMORY_SEGMENT_SZ_256K   = 32'h0004_0000;
  localparam logic [31:0] TOP_OF_MEMORY_SEGMENT_SZ_512K   = 32'h0008_0000;
  localparam logic [31:0] TOP_OF_MEMORY_SEGMENT_SZ_1M     = 32'h0010_0000;

  typedef enum logic [1:0] {
    SEG_128K = 2'h0,
    SEG_256K = 2'h1,
    SEG_512K = 2'h2,
    SEG_1M   = 2'h3
  } esmc_seg_size_e;

  // Control register fields held by the block
  typedef struct packed {
    logic           highEn;
    logic           errFlag;
    logic           l1Allow;
    logic           l2Allow;
    esmc_seg_size_e segSize;
    logic           tsegOn;
  } esmc_ctrl_s;

  // Per-cycle decode answer for one host address strobe
  typedef struct packed {
    logic valid;
    logic smmAccess;
    logic compatHit;
    logic highHit;
    logic tsegHit;
    logic pciForward;
    logic smramDram;
    logic wbCacheable;
    logic l1Cache;
    logic l2Cache;
    logic uncacheable;
    logic violation;
  } esmc_decode_s;

endpackage

// >>> esmc_range_hit.sv
// Address window comparator: base inclusive, limit exclusive
`timescale 1ns/10ps
module esmc_range_hit #(
  parameter int AW = 32
) (
  input  wire logic [AW-1:0] addr,
  input  wire logic [AW-1:0] base,
  input  wire logic [AW-1:0] limit,
  output logic               hit
);

  assign hit = (addr >= base) && (addr < limit);

endmodule

// >>> esmc_ctrl.sv
// Extended system-management memory control register and host cycle decode
//
// Contract
// - High enable bit shows the high window at 100A0000h; clear hides it.
// - Non-SMM processor access to high or top segment windows sets error flag.
// - Writing one to the error flag clears it; software must do so.
// - Cache policy bit always reads zero, meaning writeback only.
// - L2 writeback caching needs both L1 and L2 allow; L2 under 32 MB DRAM, which the block does not check against memoryTop.
// - Two-bit size selects 128 KB, 256 KB, 512 KB or 1 MB below memory top.
// - Enabled top segment is released from DRAM and forwarded to PCI.
// - Top segment sits at 256 MB plus memory top minus segment size.
// - Top segment appears only with global enable and segment enable both set.
// - Extended memory above 1 MB is treated as writeback cacheable.
// - Compatible memory in A and B segments below 1 MB is uncacheable.
// - Global enable must be set for any extended function to act.
// - Address strobe with SMM active indicator marks an SMM access.
`timescale 1ns/10ps
module esmc_ctrl #(
  parameter int AW = 32
) (
  input  wire logic                 clk,
  input  wire logic                 rst_n,
  input  wire logic                 cfgWrEn,
  input  wire logic                 cfgRdEn,
  input  wire logic [7:0]           cfgAddr,
  input  wire logic [7:0]           cfgWrData,
  output logic      [7:0]           cfgRdData_r,
  input  wire logic                 globalSmEnable,
  input  wire logic [AW-1:0]        memoryTop,
  input  wire logic                 hostAddrStrobe_n,
  input  wire logic [AW-1:0]        hostAddr,
  input  wire logic                 smmActive_n,
  output esmc_pkg::esmc_decode_s    decode_r
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    esmc_pkg::esmc_ctrl_s   ctrl;
    logic [7:0]             rdData;
    esmc_pkg::esmc_decode_s dec;
  } esmc_state_s;

  esmc_state_s state_r;
  esmc_state_s state_nxt;

  logic          strobe;
  logic          smmAccess;
  logic          wrHit;
  logic          rdHit;
  logic          highVisible;
  logic          tsegVisible;
  logic          compatHit;
  logic          highHit;
  logic          tsegHit;
  logic          dramTopHit;
  logic          violation;
  logic [AW-1:0] segSizeBytes;
  logic [AW-1:0] tsegBase;
  logic [AW-1:0] tsegLimit;
  logic [AW-1:0] dramTopBase;
  logic [AW-1:0] highLimit;
  logic [AW-1:0] compatLimit;
  logic [7:0]    ctrlView;

  // ----------------------------------------------------------------
  // Window geometry
  // ----------------------------------------------------------------
  always_comb
  begin
    unique case (state_r.ctrl.segSize)
      esmc_pkg::SEG_128K: segSizeBytes = AW'(esmc_pkg::TOP_OF_MEMORY_SEGMENT_SZ_128K);
      esmc_pkg::SEG_256K: segSizeBytes = AW'(esmc_pkg::TOP_OF_MEMORY_SEGMENT_SZ_256K);
      esmc_pkg::SEG_512K: segSizeBytes = AW'(esmc_pkg::TOP_OF_MEMORY_SEGMENT_SZ_512K);
      esmc_pkg::SEG_1M:   segSizeBytes = AW'(esmc_pkg::TOP_OF_MEMORY_SEGMENT_SZ_1M);
    endcase
  end

  // Wraps silently if memory top is near the address ceiling
  assign tsegLimit   = AW'(memoryTop + AW'(esmc_pkg::TOP_OF_MEMORY_SEGMENT_PHYS_OFS));
  assign tsegBase    = AW'(tsegLimit - segSizeBytes);
  assign dramTopBase = AW'(memoryTop - segSizeBytes);
  assign highLimit   = AW'(esmc_pkg::HIGH_BASE + esmc_pkg::HIGH_SIZE);
  assign compatLimit = AW'(esmc_pkg::COMPAT_BASE + esmc_pkg::COMPAT_SIZE);

  esmc_range_hit #(.AW(AW)) uCompat (
    .addr  (hostAddr),
    .base  (AW'(esmc_pkg::COMPAT_BASE)),
    .limit (compatLimit),
    .hit   (compatHit)
  );

  esmc_range_hit #(.AW(AW)) uHigh (
    .addr  (hostAddr),
    .base  (AW'(esmc_pkg::HIGH_BASE)),
    .limit (highLimit),
    .hit   (highHit)
  );

  esmc_range_hit #(.AW(AW)) uTseg (
    .addr  (hostAddr),
    .base  (tsegBase),
    .limit (tsegLimit),
    .hit   (tsegHit)
  );

  esmc_range_hit #(.AW(AW)) uDramTop (
    .addr  (hostAddr),
    .base  (dramTopBase),
    .limit (memoryTop),
    .hit   (dramTopHit)
  );

  // ----------------------------------------------------------------
  // Cycle classification
  // ----------------------------------------------------------------
  assign strobe      = !hostAddrStrobe_n;
  assign smmAccess   = strobe && !smmActive_n;
  assign highVisible = globalSmEnable && state_r.ctrl.highEn;
  assign tsegVisible = globalSmEnable && state_r.ctrl.tsegOn;
  assign violation   = strobe && smmActive_n &&
                       ((highHit && highVisible) || (tsegHit && tsegVisible));
  assign wrHit       = cfgWrEn && (cfgAddr == esmc_pkg::CTRL_OFFSET);
  assign rdHit       = cfgRdEn && (cfgAddr == esmc_pkg::CTRL_OFFSET);

  always_comb
  begin
    ctrlView                           = 8'h00;
    ctrlView[esmc_pkg::BIT_HIGH_EN]    = state_r.ctrl.highEn;
    ctrlView[esmc_pkg::BIT_ERROR]      = state_r.ctrl.errFlag;
    ctrlView[esmc_pkg::BIT_CACHE_POL]  = esmc_pkg::CACHE_POL_WB;
    ctrlView[esmc_pkg::BIT_L1_ALLOW]   = state_r.ctrl.l1Allow;
    ctrlView[esmc_pkg::BIT_L2_ALLOW]   = state_r.ctrl.l2Allow;
    ctrlView[esmc_pkg::BIT_SIZE_HI]    = state_r.ctrl.segSize[1];
    ctrlView[esmc_pkg::BIT_SIZE_LO]    = state_r.ctrl.segSize[0];
    ctrlView[esmc_pkg::BIT_TOP_OF_MEMORY_SEGMENT_ON]    = state_r.ctrl.tsegOn;
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    state_nxt = state_r;
    if (wrHit)
    begin
      state_nxt.ctrl.highEn  = cfgWrData[esmc_pkg::BIT_HIGH_EN];
      state_nxt.ctrl.l1Allow = cfgWrData[esmc_pkg::BIT_L1_ALLOW];
      state_nxt.ctrl.l2Allow = cfgWrData[esmc_pkg::BIT_L2_ALLOW];
      state_nxt.ctrl.segSize = esmc_pkg::esmc_seg_size_e'(cfgWrData[esmc_pkg::BIT_SIZE_HI:esmc_pkg::BIT_SIZE_LO]);
      state_nxt.ctrl.tsegOn  = cfgWrData[esmc_pkg::BIT_TOP_OF_MEMORY_SEGMENT_ON];
      if (cfgWrData[esmc_pkg::BIT_ERROR])
      begin
        state_nxt.ctrl.errFlag = 1'b0;
      end
    end
    // Set after clear so a hit in the clearing cycle is kept
    if (violation)
    begin
      state_nxt.ctrl.errFlag = 1'b1;
    end

    // Read data is registered: one cycle after the read strobe
    state_nxt.rdData = rdHit ? ctrlView : 8'h00;

    state_nxt.dec.valid       = strobe;
    state_nxt.dec.smmAccess   = smmAccess;
    state_nxt.dec.compatHit   = strobe && compatHit && globalSmEnable;
    state_nxt.dec.highHit     = strobe && highHit && highVisible;
    state_nxt.dec.tsegHit     = strobe && tsegHit && tsegVisible;
    state_nxt.dec.pciForward  = strobe && dramTopHit && tsegVisible;
    state_nxt.dec.smramDram   = smmAccess &&
                                ((highHit && highVisible) || (tsegHit && tsegVisible) ||
                                 (compatHit && globalSmEnable));
    state_nxt.dec.wbCacheable = smmAccess &&
                                ((highHit && highVisible) || (tsegHit && tsegVisible));
    state_nxt.dec.l1Cache     = state_nxt.dec.wbCacheable && state_r.ctrl.l1Allow;
    state_nxt.dec.l2Cache     = state_nxt.dec.wbCacheable && state_r.ctrl.l1Allow &&
                                state_r.ctrl.l2Allow;
    state_nxt.dec.uncacheable = smmAccess && compatHit && globalSmEnable;
    state_nxt.dec.violation   = violation;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_r <= '0;
    end
    else
    begin
      state_r <= state_nxt;
    end
  end

  assign cfgRdData_r = state_r.rdData;
  assign decode_r    = state_r.dec;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence sViolate;
    !hostAddrStrobe_n && smmActive_n && globalSmEnable &&
    ((highHit && state_r.ctrl.highEn) || (tsegHit && state_r.ctrl.tsegOn));
  endsequence

  sequence sClearErr;
    cfgWrEn && (cfgAddr == esmc_pkg::CTRL_OFFSET) && cfgWrData[esmc_pkg::BIT_ERROR];
  endsequence

  a_err_set_hit: assert property (sViolate |=> state_r.ctrl.errFlag && decode_r.violation)
    else $error("error flag not set after non-SMM access");

  a_err_clear_w1c: assert property ((sClearErr and !violation) |=> !state_r.ctrl.errFlag)
    else $error("error flag not cleared by write of one");

  a_err_sticky: assert property (state_r.ctrl.errFlag && !(wrHit && cfgWrData[esmc_pkg::BIT_ERROR]) |=>
                                 state_r.ctrl.errFlag)
    else $error("error flag dropped without clear");

  a_err_set_wins: assert property ((sClearErr and sViolate) |=> state_r.ctrl.errFlag)
    else $error("clear beat a simultaneous violation");

  a_cache_pol_zero: assert property (rdHit |=> cfgRdData_r[esmc_pkg::BIT_CACHE_POL] == 1'b0)
    else $error("cache policy bit read as one");

  a_high_gated: assert property (decode_r.highHit |-> $past(globalSmEnable && state_r.ctrl.highEn))
    else $error("high window shown while disabled");

  a_top_of_memory_segment_gated: assert property (decode_r.tsegHit || decode_r.pciForward |->
                                 $past(globalSmEnable) && $past(state_r.ctrl.tsegOn))
    else $error("top segment shown while disabled");

  a_l2_needs_l1: assert property (decode_r.l2Cache |-> decode_r.l1Cache && $past(state_r.ctrl.l2Allow))
    else $error("L2 caching without L1 allow");

  a_smm_wb: assert property (!hostAddrStrobe_n && !smmActive_n && globalSmEnable && highHit &&
                             state_r.ctrl.highEn |=> decode_r.wbCacheable && decode_r.smmAccess)
    else $error("extended SMM access not marked writeback");

  a_compat_uc: assert property (decode_r.uncacheable |->
                                decode_r.compatHit && !decode_r.wbCacheable &&
                                !decode_r.l1Cache && !decode_r.l2Cache)
    else $error("compatible space marked cacheable");

  // ----------------------------------------------------------------
  // Register bus and decode checks
  // ----------------------------------------------------------------
  sequence sCtrlWrite;
    cfgWrEn && (cfgAddr == esmc_pkg::CTRL_OFFSET);
  endsequence

  sequence sHostStrobe;
    !hostAddrStrobe_n;
  endsequence

  // Stale read data would look like a second read to a polling host
  a_rd_idle_zero: assert property (!rdHit |=> cfgRdData_r == 8'h00)
    else $error("read data not zero without a read");

  a_rd_err_view: assert property (rdHit |=>
                                  cfgRdData_r[esmc_pkg::BIT_ERROR] == $past(state_r.ctrl.errFlag))
    else $error("error flag not shown on read");

  a_write_lands: assert property (sCtrlWrite |=>
                                  state_r.ctrl.highEn == $past(cfgWrData[esmc_pkg::BIT_HIGH_EN]) &&
                                  state_r.ctrl.l1Allow == $past(cfgWrData[esmc_pkg::BIT_L1_ALLOW]) &&
                                  state_r.ctrl.tsegOn == $past(cfgWrData[esmc_pkg::BIT_TOP_OF_MEMORY_SEGMENT_ON]))
    else $error("control write did not land");

  a_size_lands: assert property (sCtrlWrite |=>
                                 state_r.ctrl.segSize ==
                                 $past(cfgWrData[esmc_pkg::BIT_SIZE_HI:esmc_pkg::BIT_SIZE_LO]))
    else $error("segment size write did not land");

  a_dec_idle: assert property (hostAddrStrobe_n |=> decode_r == '0)
    else $error("decode shown without a strobe");

  a_smm_flag: assert property (sHostStrobe |=>
                               decode_r.valid && decode_r.smmAccess == $past(!smmActive_n))
    else $error("SMM access marked wrongly");

  a_viol_non_smm: assert property (decode_r.violation |->
                                   !decode_r.smmAccess && (decode_r.highHit || decode_r.tsegHit))
    else $error("violation without non-SMM window hit");

  a_global_gates: assert property (!globalSmEnable |=>
                                   !decode_r.highHit && !decode_r.tsegHit &&
                                   !decode_r.compatHit && !decode_r.violation)
    else $error("window shown without global enable");

  a_err_no_spur: assert property (!state_r.ctrl.errFlag && !violation |=> !state_r.ctrl.errFlag)
    else $error("error flag set without violation");

  a_wb_needs_smm: assert property (decode_r.wbCacheable |->
                                   decode_r.smmAccess && (decode_r.highHit || decode_r.tsegHit))
    else $error("writeback marked outside extended SMM access");

  a_l1_allow: assert property (decode_r.l1Cache |->
                               decode_r.wbCacheable && $past(state_r.ctrl.l1Allow))
    else $error("L1 caching without L1 allow");

endmodule

// >>> esmc_host_model.sv
// Host processor model that issues one-cycle memory strobes
`timescale 1ns/10ps
module esmc_host_model (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        reqGo,
  input  wire logic [31:0] reqAddr,
  input  wire logic        reqSmm,
  output logic             hostAddrStrobe_n,
  output logic      [31:0] hostAddr,
  output logic             smmActive_n
);
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      hostAddrStrobe_n <= 1'b1;
      hostAddr         <= 32'h0000_0000;
      smmActive_n      <= 1'b1;
    end
    else if (reqGo)
    begin
      hostAddrStrobe_n <= 1'b0;
      hostAddr         <= reqAddr;
      smmActive_n      <= ~reqSmm;
    end
    else
    begin
      // Released bus toggles so a stale address never looks valid
      hostAddrStrobe_n <= 1'b1;
      hostAddr         <= ~hostAddr;
      smmActive_n      <= 1'b1;
    end
  end
endmodule

// >>> esmc_ctrl_tb_top.sv
// Self-checking bench for the extended SM memory control block
`timescale 1ns/10ps
module esmc_ctrl_tb_top;
  typedef struct packed {
    logic [7:0]  ctrl;
    logic        glb;
    logic [31:0] addr;
    logic        smm;
    logic [11:0] dec;
  } esmc_row_s;
  logic                   clk, rst_n, cfgWrEn, cfgRdEn, globalSmEnable, reqGo, reqSmm;
  logic [7:0]             cfgAddr, cfgWrData, cfgRdData_r, rd;
  logic [31:0]            memoryTop, hostAddr, reqAddr;
  logic                   hostAddrStrobe_n, smmActive_n;
  logic [11:0]            dec;
  esmc_pkg::esmc_decode_s decode_r;
  int                     nErrors, samplesChecked;
  esmc_row_s              rows [16] = '{
    '{8'h99, 1'b1, 32'h100a_0000, 1'b1, 12'hd3c}, '{8'h99, 1'b1, 32'h100b_ffff, 1'b1, 12'hd3c},
    '{8'h99, 1'b1, 32'h100c_0000, 1'b1, 12'hc00}, '{8'h99, 1'b1, 32'h10fe_0000, 1'b1, 12'hcbc},
    '{8'h99, 1'b1, 32'h10fd_ffff, 1'b1, 12'hc00}, '{8'h99, 1'b1, 32'h00fe_0000, 1'b0, 12'h840},
    '{8'h99, 1'b1, 32'h000a_0000, 1'b1, 12'he22}, '{8'h99, 1'b0, 32'h000a_0000, 1'b1, 12'hc00},
    '{8'h81, 1'b0, 32'h100a_0000, 1'b1, 12'hc00}, '{8'h93, 1'b1, 32'h10fc_0000, 1'b1, 12'hcb8},
    '{8'h95, 1'b1, 32'h10f8_0000, 1'b1, 12'hcb8}, '{8'hbf, 1'b1, 32'h10f0_0000, 1'b1, 12'hcbc},
    '{8'hbf, 1'b1, 32'h10ef_ffff, 1'b1, 12'hc00}, '{8'h16, 1'b1, 32'h10f0_0000, 1'b1, 12'hc00},
    '{8'h16, 1'b1, 32'h00f0_0000, 1'b0, 12'h800}, '{8'h89, 1'b1, 32'h100a_0000, 1'b1, 12'hd30}};

  esmc_ctrl #(.AW(32)) u_dut (
    .clk              (clk),
    .rst_n            (rst_n),
    .cfgWrEn          (cfgWrEn),
    .cfgRdEn          (cfgRdEn),
    .cfgAddr          (cfgAddr),
    .cfgWrData        (cfgWrData),
    .cfgRdData_r      (cfgRdData_r),
    .globalSmEnable   (globalSmEnable),
    .memoryTop        (memoryTop),
    .hostAddrStrobe_n (hostAddrStrobe_n),
    .hostAddr         (hostAddr),
    .smmActive_n      (smmActive_n),
    .decode_r         (decode_r)
  );
  esmc_host_model u_host (
    .clk              (clk),
    .rst_n            (rst_n),
    .reqGo            (reqGo),
    .reqAddr          (reqAddr),
    .reqSmm           (reqSmm),
    .hostAddrStrobe_n (hostAddrStrobe_n),
    .hostAddr         (hostAddr),
    .smmActive_n      (smmActive_n)
  );

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [11:0] seen, input logic [11:0] exp);
    samplesChecked++;
    if (seen !== exp)
    begin
      nErrors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic printVerdict();
    $display("comparisons %0d mismatches %0d", samplesChecked, nErrors);
    if (nErrors == 0 && samplesChecked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic cfgWr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    cfgWrEn   <= 1'b1;
    cfgAddr   <= a;
    cfgWrData <= d;
    @(posedge clk);
    cfgWrEn <= 1'b0;
  endtask
  task automatic cfgRd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    cfgRdEn <= 1'b1;
    cfgAddr <= a;
    @(posedge clk);
    cfgRdEn <= 1'b0;
    #1 d = cfgRdData_r;
  endtask
  // Model drives the strobe one edge after the request; decode lands one edge later
  task automatic hostCyc(input logic [31:0] a, input logic s, output logic [11:0] d);
    @(posedge clk);
    reqGo   <= 1'b1;
    reqAddr <= a;
    reqSmm  <= s;
    @(posedge clk);
    reqGo <= 1'b0;
    @(posedge clk);
    #1 d = decode_r;
  endtask

  // ----------------------------------------------------------------
  // Clock, watchdog and sequence
  // ----------------------------------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial
  begin
    repeat (3000) @(posedge clk);
    nErrors++;
    printVerdict();
  end
  initial
  begin
    {rst_n, cfgWrEn, cfgRdEn, globalSmEnable, reqGo, reqSmm} = 6'h00;
    {cfgAddr, cfgWrData, reqAddr} = 48'h0;
    memoryTop = 32'h0100_0000;
    nErrors = 0;
    samplesChecked = 0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    cfgRd(8'h71, rd);
    check({4'h0, rd}, 12'h000);
    check(decode_r, 12'h000);
    $display("reset test done");
    foreach (rows[i])
    begin
      @(posedge clk);
      globalSmEnable <= rows[i].glb;
      cfgWr(8'h71, rows[i].ctrl);
      cfgRd(8'h71, rd);
      check({4'h0, rd}, {4'h0, rows[i].ctrl & 8'h9f});
      hostCyc(rows[i].addr, rows[i].smm, dec);
      check(dec, rows[i].dec);
    end
    $display("decode table done");
    cfgWr(8'h72, 8'hff);
    cfgRd(8'h70, rd);
    check({4'h0, rd}, 12'h000);
    cfgRd(8'h71, rd);
    check({4'h0, rd}, 12'h089);
    $display("unmapped test done");
    cfgWr(8'h71, 8'h81);
    hostCyc(32'h100a_0000, 1'b0, dec);
    check(dec, 12'h901);
    cfgWr(8'h71, 8'h81);
    cfgRd(8'h71, rd);
    check({4'h0, rd}, 12'h0c1);
    cfgWr(8'h71, 8'hc1);
    cfgRd(8'h71, rd);
    check({4'h0, rd}, 12'h081);
    // Violation and clear taken at the same edge
    @(posedge clk);
    reqGo   <= 1'b1;
    reqAddr <= 32'h100a_0000;
    reqSmm  <= 1'b0;
    @(posedge clk);
    reqGo     <= 1'b0;
    cfgWrEn   <= 1'b1;
    cfgAddr   <= 8'h71;
    cfgWrData <= 8'hc1;
    @(posedge clk);
    cfgWrEn <= 1'b0;
    cfgRd(8'h71, rd);
    check({4'h0, rd}, 12'h0c1);
    cfgWr(8'h71, 8'h41);
    hostCyc(32'h10fe_0000, 1'b0, dec);
    check(dec, 12'h881);
    hostCyc(32'h100a_0000, 1'b0, dec);
    check(dec, 12'h800);
    cfgRd(8'h71, rd);
    check({4'h0, rd}, 12'h041);
    $display("error flag test done");
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    cfgRd(8'h71, rd);
    check({4'h0, rd}, 12'h000);
    $display("second reset test done");
    printVerdict();
  end
endmodule
